// ===== hdl/brcs_pkg.sv
// Purpose: shared constants and types for the burst read configuration sequencer
// Assumes: 16-bit configuration word, word addresses of ADDR_W bits
// Notes: field positions and codes of the configuration word live here; the bench repeats the bit positions
//
// Notes on behaviour
// [R01] order bit 0 gives interleaved word order, 1 gives sequential order
// [R02] edge select bit 0 makes falling burst clock edge active, 1 rising
// [R03] length code 001 gives 4 words, 010 gives 8, 111 continuous
// [R04] the three bits between edge select and length are reserved, unused
// [R05] read select 0 means synchronous bursts, 1 asynchronous; 1 after reset
// [R06] latency codes 010 to 110 give first access of 4 to 8 cycles
// [R07] host never pairs first latency 4 with inter-word latency 2
// [R08] halving bit doubles both first-access and inter-word latencies
// [R09] ready timing 0 drops ready on invalid edge, 1 drops one cycle earlier
// [R10] sequential 4/8 bursts increment and wrap inside the aligned group
// [R11] interleaved bursts give start address xor an incrementing count
// [R12] continuous bursts increment linearly with no wrap at any boundary
// [R13] first latency counts from address latch to first data word
// [R14] inter-word bit 0 gives a word each cycle, 1 every second cycle
// [R15] host writes only listed codes; the device flags any other code

package brcs_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int CFG_W = 16;
  localparam int ADDR_W = 21;
  localparam int FIFO_DEPTH = 4;
  localparam int LOW_W = 3;
  localparam int CNT_W = 5;

  // ----------------------------------------------------------------------
  // configuration word layout
  // ----------------------------------------------------------------------
  localparam int RSEL_BIT = 15;
  localparam int XLAT_LO = 11;
  localparam int XLAT_W = 3;
  localparam int HALVE_BIT = 10;
  localparam int YLAT_BIT = 9;
  localparam int RDY_BIT = 8;
  localparam int ORDER_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam int LEN_LO = 0;
  localparam int LEN_W = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h8000;
  localparam logic [CFG_W-1:0] CFG_MASK = 16'hBFC7;

  // ----------------------------------------------------------------------
  // codes and derived figures
  // ----------------------------------------------------------------------
  localparam logic [XLAT_W-1:0] XLAT_MIN_CODE = 3'h2;
  localparam logic [XLAT_W-1:0] XLAT_MAX_CODE = 3'h6;
  localparam logic [CNT_W-1:0] XLAT_OFFSET = 5'h02;
  localparam logic [2:0] YLAT_ONE = 3'h1;
  localparam logic [2:0] YLAT_TWO = 3'h2;
  localparam logic [LEN_W-1:0] LEN_4 = 3'h1;
  localparam logic [LEN_W-1:0] LEN_8 = 3'h2;
  localparam logic [LEN_W-1:0] LEN_CONT = 3'h7;
  localparam logic [3:0] WORDS_4 = 4'h4;
  localparam logic [3:0] WORDS_8 = 4'h8;
  localparam logic [LOW_W-1:0] MASK_4 = 3'h3;
  localparam logic [LOW_W-1:0] MASK_8 = 3'h7;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_WAIT = 3'h2,
    S_BURST = 3'h4
  } brcs_state_t;

endpackage : brcs_pkg

// ===== hdl/brcs_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: flush empties it in one cycle; contents are not reset
`timescale 1ns/10ps
`default_nettype none

module brcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty = (wptr == rptr);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rptr[AW-1:0]];

  // write pointer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr <= '0;
    end else if (flush_i) begin
      wptr <= '0;
    end else if (in_valid_i && !full) begin
      wptr <= wptr + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rptr <= '0;
    end else if (flush_i) begin
      rptr <= '0;
    end else if (out_ready_i && !empty) begin
      rptr <= rptr + 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full && !flush_i) begin
      mem[wptr[AW-1:0]] <= in_data_i;
    end
  end

endmodule : brcs_fifo

`default_nettype wire

// ===== hdl/brcs_seq.sv
// Purpose: configuration word and burst address sequencing for synchronous reads
// Assumes: host changes the edge select bit only while no burst runs
// Notes: link logic runs on the burst clock, on the selected active edge
`timescale 1ns/10ps
`default_nettype none

module brcs_seq (
  // system clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration port
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_bad_o,
  output logic async_mode_o,
  output logic busy_o,
  // burst link
  input wire logic burst_clk_i,
  input wire logic ce_n_i,
  input wire logic latch_n_i,
  input wire logic [20:0] start_addr_i,
  input wire logic fetch_stall_i,
  output logic [20:0] word_addr_o,
  output logic word_valid_o,
  output logic ready_o
);

  localparam int AW = brcs_pkg::ADDR_W;
  localparam int LW = brcs_pkg::LOW_W;
  localparam int CW = brcs_pkg::CNT_W;

  // ----------------------------------------------------------------------
  // system domain: reset release and configuration word
  // ----------------------------------------------------------------------
  logic rst_ff1;
  logic rst_n;
  logic [15:0] cfg;
  logic cfg_tgl;
  logic busy_s1;
  logic busy_s2;
  logic lbusy;

  // async assert, release through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_ff1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_n <= rst_ff1;
    end
  end

  // reserved bits are dropped at write so they read as zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= brcs_pkg::CFG_RESET; // see [R05]
      cfg_tgl <= 1'b0;
    end else if (cfg_wr_i) begin
      cfg <= cfg_wdata_i & brcs_pkg::CFG_MASK; // see [R04]
      cfg_tgl <= !cfg_tgl;
    end
  end

  // flag unlisted codes and the forbidden 4-2 pairing
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_bad_o <= 1'b0;
    end else begin
      cfg_bad_o <= (cfg[brcs_pkg::XLAT_LO +: brcs_pkg::XLAT_W] < brcs_pkg::XLAT_MIN_CODE)
        || (cfg[brcs_pkg::XLAT_LO +: brcs_pkg::XLAT_W] > brcs_pkg::XLAT_MAX_CODE)
        || ((cfg[brcs_pkg::LEN_LO +: brcs_pkg::LEN_W] != brcs_pkg::LEN_4)
        && (cfg[brcs_pkg::LEN_LO +: brcs_pkg::LEN_W] != brcs_pkg::LEN_8)
        && (cfg[brcs_pkg::LEN_LO +: brcs_pkg::LEN_W] != brcs_pkg::LEN_CONT)) // see [R15]
        || ((cfg[brcs_pkg::XLAT_LO +: brcs_pkg::XLAT_W] == brcs_pkg::XLAT_MIN_CODE)
        && cfg[brcs_pkg::YLAT_BIT]); // see [R07]
    end
  end

  // readback, mode and busy status
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_o <= brcs_pkg::CFG_RESET;
      async_mode_o <= 1'b1;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      cfg_rdata_o <= cfg;
      async_mode_o <= cfg[brcs_pkg::RSEL_BIT];
      busy_s1 <= lbusy;
      busy_s2 <= busy_s1;
      busy_o <= busy_s2;
    end
  end

  // ----------------------------------------------------------------------
  // link clock: active edge chosen by the configuration
  // ----------------------------------------------------------------------
  logic act_clk;

  // glitches if the bit moves mid-burst; host keeps it still then
  assign act_clk = cfg[brcs_pkg::EDGE_BIT] ? burst_clk_i : !burst_clk_i; // see [R02]

  logic lrst1;
  logic lrst_n;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic [15:0] lcfg;

  // link reset released on the link clock
  always_ff @(posedge act_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst1 <= 1'b1;
      lrst_n <= lrst1;
    end
  end

  // toggle handshake; word is stable long before the toggle lands
  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      lcfg <= brcs_pkg::CFG_RESET;
    end else begin
      tgl_s1 <= cfg_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      if (tgl_s2 != tgl_s3) begin
        lcfg <= cfg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // decoded fields
  // ----------------------------------------------------------------------
  logic l_rsel;
  logic l_halve;
  logic l_rdy;
  logic l_order;
  logic [brcs_pkg::LEN_W-1:0] l_len;
  logic [CW-1:0] x_base;
  logic [CW-1:0] x_eff;
  logic [2:0] y_base;
  logic [CW-1:0] y_eff;
  logic cont;
  logic [LW-1:0] wmask;
  logic [3:0] burst_words;

  assign l_rsel = lcfg[brcs_pkg::RSEL_BIT];
  assign l_halve = lcfg[brcs_pkg::HALVE_BIT];
  assign l_rdy = lcfg[brcs_pkg::RDY_BIT];
  assign l_order = lcfg[brcs_pkg::ORDER_BIT];
  assign l_len = lcfg[brcs_pkg::LEN_LO +: brcs_pkg::LEN_W];

  // latency codes map to code plus offset cycles
  assign x_base = {2'h0, lcfg[brcs_pkg::XLAT_LO +: brcs_pkg::XLAT_W]}
    + brcs_pkg::XLAT_OFFSET; // see [R06]
  assign y_base = lcfg[brcs_pkg::YLAT_BIT] ? brcs_pkg::YLAT_TWO : brcs_pkg::YLAT_ONE; // see [R14]
  // halved internal clock doubles both latencies
  assign x_eff = l_halve ? {x_base[CW-2:0], 1'b0} : x_base; // see [R08]
  assign y_eff = l_halve ? {1'b0, y_base, 1'b0} : {2'h0, y_base}; // see [R08]

  // burst length; unlisted codes behave as 4 words
  assign cont = (l_len == brcs_pkg::LEN_CONT); // see [R03]
  assign wmask = (l_len == brcs_pkg::LEN_8) ? brcs_pkg::MASK_8 : brcs_pkg::MASK_4;
  assign burst_words = (l_len == brcs_pkg::LEN_8) ? brcs_pkg::WORDS_8 : brcs_pkg::WORDS_4;

  // ----------------------------------------------------------------------
  // burst state machine
  // ----------------------------------------------------------------------
  brcs_pkg::brcs_state_t state;
  brcs_pkg::brcs_state_t next_state;
  logic [CW-1:0] tick_cnt;
  logic [3:0] words_out;
  logic start;
  logic burst_on;
  logic out_time;
  logic words_all;
  logic pop;
  logic fifo_valid;
  logic [AW-1:0] fifo_data;

  // synchronous bursts only when read select is 0
  assign start = (state == brcs_pkg::S_IDLE) && !l_rsel && !ce_n_i && !latch_n_i; // see [R05]
  assign burst_on = (state != brcs_pkg::S_IDLE);
  assign out_time = burst_on && !ce_n_i && (tick_cnt == '0);
  assign words_all = !cont && (words_out == burst_words); // see [R03]
  assign pop = out_time && !words_all && fifo_valid;
  assign lbusy = burst_on;

  always_comb begin
    next_state = state;
    case (state)
      brcs_pkg::S_IDLE: begin
        if (start) begin
          next_state = brcs_pkg::S_WAIT;
        end
      end
      brcs_pkg::S_WAIT: begin
        if (ce_n_i) begin
          next_state = brcs_pkg::S_IDLE;
        end else if (tick_cnt == '0) begin
          next_state = brcs_pkg::S_BURST;
        end
      end
      brcs_pkg::S_BURST: begin
        if (ce_n_i || (out_time && words_all)) begin
          next_state = brcs_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = brcs_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state <= brcs_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one counter times first access then each word slot
  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      tick_cnt <= '0;
    end else if (start) begin
      tick_cnt <= x_eff - 1'b1; // see [R13]
    end else if (out_time) begin
      tick_cnt <= y_eff - 1'b1; // see [R14]
    end else if (burst_on) begin
      tick_cnt <= tick_cnt - 1'b1;
    end
  end

  // words handed out so far
  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      words_out <= '0;
    end else if (start) begin
      words_out <= '0;
    end else if (pop) begin
      words_out <= words_out + 1'b1;
    end
  end

  // output word; a slot with nothing fetched carries invalid data
  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      word_addr_o <= '0;
      word_valid_o <= 1'b0;
    end else if (start || !burst_on || ce_n_i) begin
      word_valid_o <= 1'b0;
    end else if (pop) begin
      word_addr_o <= fifo_data;
      word_valid_o <= 1'b1;
    end else if (out_time) begin
      word_valid_o <= 1'b0;
    end
  end

  // early mode warns during the cycle before an invalid slot
  logic miss_next;
  assign miss_next = out_time && !words_all && !fifo_valid;
  assign ready_o = !burst_on ? 1'b1
    : (l_rdy ? (word_valid_o && !miss_next) : word_valid_o); // see [R09]

  // ----------------------------------------------------------------------
  // address generator ahead of the output, through the FIFO
  // ----------------------------------------------------------------------
  logic [AW-1:0] start_q;
  logic [AW-1:0] gen_idx;
  logic [AW-1:0] push_addr;
  logic [LW-1:0] low3;
  logic [LW-1:0] idx3;
  logic [LW-1:0] seq_low;
  logic [LW-1:0] int_low;
  logic gen_on;
  logic push;
  logic fifo_ready;

  assign low3 = start_q[LW-1:0];
  assign idx3 = gen_idx[LW-1:0];
  assign seq_low = (low3 + idx3) & wmask; // see [R10]
  assign int_low = (low3 ^ idx3) & wmask; // see [R11]
  // continuous ignores the order bit and never wraps
  assign push_addr = cont ? (start_q + gen_idx) // see [R12]
    : {start_q[AW-1:LW], (low3 & ~wmask) | (l_order ? seq_low : int_low)}; // see [R01]
  // stall on array wait or a full FIFO
  assign gen_on = burst_on && !ce_n_i && !fetch_stall_i
    && (cont || (gen_idx < {{(AW-4){1'b0}}, burst_words}));
  assign push = gen_on && fifo_ready;

  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      start_q <= '0;
      gen_idx <= '0;
    end else if (start) begin
      start_q <= start_addr_i;
      gen_idx <= '0;
    end else if (push) begin
      gen_idx <= gen_idx + 1'b1;
    end
  end

  brcs_fifo #(
    .WIDTH(AW),
    .DEPTH(brcs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(act_clk),
    .rst_n_i(lrst_n),
    .flush_i(start),
    .in_valid_i(gen_on),
    .in_ready_o(fifo_ready),
    .in_data_i(push_addr),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [CW-1:0] lat_cnt;
  logic [CW-1:0] gap_cnt;
  logic had_push;
  logic [AW-1:0] last_push;
  logic [LW-1:0] seq_exp;

  assign seq_exp = (last_push[LW-1:0] + 1'b1) & wmask;

  // helper counters read only by the checks
  always_ff @(posedge act_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lat_cnt <= '0;
      gap_cnt <= '0;
      had_push <= 1'b0;
      last_push <= '0;
    end else begin
      lat_cnt <= start ? 5'h01 : lat_cnt + 1'b1;
      gap_cnt <= out_time ? 5'h01 : gap_cnt + 1'b1;
      if (start) begin
        had_push <= 1'b0;
      end else if (push) begin
        had_push <= 1'b1;
        last_push <= push_addr;
      end
    end
  end

  default clocking cb @(posedge act_clk); endclocking
  default disable iff (!lrst_n);

  chk_async_idle: assert property ( // see [R05]
    (state == brcs_pkg::S_IDLE && l_rsel) |=> state == brcs_pkg::S_IDLE)
    else $error("burst started in asynchronous mode");
  chk_first_latency: assert property ( // see [R13]
    (state == brcs_pkg::S_WAIT && !ce_n_i && tick_cnt == '0) |-> lat_cnt == x_eff)
    else $error("first word not at first-access latency");
  chk_halved_first: assert property ( // see [R08]
    (state == brcs_pkg::S_WAIT && !ce_n_i && tick_cnt == '0 && l_halve)
    |-> lat_cnt == {x_base[CW-2:0], 1'b0})
    else $error("halved first latency not doubled");
  chk_word_gap: assert property ( // see [R14]
    (state == brcs_pkg::S_BURST && out_time) |-> gap_cnt == y_eff)
    else $error("word slot spacing wrong");
  chk_seq_step: assert property ( // see [R10]
    (push && had_push && !cont && l_order) |-> (push_addr[LW-1:0] & wmask) == seq_exp)
    else $error("sequential order step wrong");
  chk_inter_xor: assert property ( // see [R11]
    (push && !cont && !l_order) |-> (push_addr[LW-1:0] ^ low3) == (idx3 & wmask))
    else $error("interleaved order wrong");
  chk_cont_step: assert property ( // see [R12]
    (push && had_push && cont) |-> push_addr == last_push + 1'b1)
    else $error("continuous address not linear");
  chk_len_limit: assert property ( // see [R03]
    (burst_on && !cont) |-> words_out <= burst_words)
    else $error("burst longer than its length");
  chk_ready_late: assert property ( // see [R09]
    (miss_next && !l_rdy && !ce_n_i) |=> (burst_on && !ce_n_i) |-> !ready_o)
    else $error("ready high on invalid slot");
  chk_ready_early: assert property ( // see [R09]
    (miss_next && l_rdy && !ce_n_i) |-> !ready_o ##1 !word_valid_o)
    else $error("ready not dropped early");

  cov_burst8: cover property (out_time && words_all && burst_words == brcs_pkg::WORDS_8);
  cov_cont: cover property (pop && cont && words_out == 4'h9);
  cov_invalid_slot: cover property (miss_next && state == brcs_pkg::S_BURST);
  cov_halved: cover property (pop && l_halve && y_eff == 5'h04);

endmodule : brcs_seq

`default_nettype wire

// ===== test/brcs_host_model.sv
// Purpose: host controller model that clocks and collects synchronous bursts
// Assumes: one frame at a time, started by a rising go_i
// Notes: burst clock runs only inside frames; latch happens on active edge 8
`timescale 1ns/10ps
`default_nettype none

module brcs_host_model (
  // frame control
  input wire logic go_i,
  input wire logic rise_i,
  input wire logic stall_i,
  input wire logic [20:0] addr_i,
  input wire logic [4:0] want_i,
  output logic done_o,
  // burst link
  input wire logic [20:0] word_addr_i,
  input wire logic word_valid_i,
  input wire logic ready_i,
  output logic kclk_o,
  output logic ce_n_o,
  output logic latch_n_o,
  output logic stall_o,
  output logic [20:0] addr_o
);
  // ----------------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------------
  int edge_n;
  int end_e;
  int nrec;
  int ge [0:15];
  logic pv;
  logic rdy10;
  logic running;
  logic [20:0] got [0:15];

  initial begin
    kclk_o = 1'b0;
    ce_n_o = 1'b1;
    latch_n_o = 1'b1;
    stall_o = 1'b0;
    addr_o = 21'h000000;
    done_o = 1'b0;
    running = 1'b0;
  end

  // clock stands still between frames
  always #3 if (running) kclk_o = ~kclk_o;

  // a new frame clears the record
  always @(posedge go_i) begin
    edge_n = 0;
    nrec = 0;
    end_e = 0;
    pv = 1'b0;
    done_o = 1'b0;
    running = 1'b1;
  end

  // everything happens on the active edge only
  always @(kclk_o) begin
    if (running && kclk_o === rise_i) begin
      edge_n = edge_n + 1;
      if (edge_n == 10) rdy10 = ready_i;
      // record each new word once, even when it stands for two cycles
      if (word_valid_i === 1'b1 && (!pv || got[nrec-1] !== word_addr_i) && nrec < 16) begin
        ge[nrec] = edge_n;
        got[nrec] = word_addr_i;
        nrec = nrec + 1;
      end
      pv = word_valid_i;
      if (end_e == 0 && edge_n > 8 && (nrec >= want_i || edge_n >= 80)) end_e = edge_n;
      #1;
      // address latched on edge 8, first latency counts from there
      ce_n_o = !(edge_n >= 7 && end_e == 0);
      latch_n_o = (edge_n != 7);
      // released address lines show the inverse, not a stale copy
      addr_o = (edge_n == 7) ? addr_i : ~addr_i;
      stall_o = stall_i && edge_n > 14 && (edge_n % 4) >= 2;
      if (end_e != 0 && edge_n >= end_e + 3) begin
        running = 1'b0;
        done_o = 1'b1;
      end
    end
  end
endmodule : brcs_host_model
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: self-checking bench for the burst read configuration sequencer
// Assumes: host model drives the burst link, bench drives the config port
// Notes: config words avoid the reserved bits except where readback is probed
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk_i, resetn_i, cfg_wr_i, cfg_bad_o, async_mode_o, busy_o;
  logic [15:0] cfg_wdata_i, cfg_rdata_o;
  logic kclk, ce_n, latch_n, stall, wvalid, rdy, go, rise, stall_req, done;
  logic [20:0] saddr, waddr, st_addr;
  logic [4:0] want;
  int err_count, checks_done, cycles;

  brcs_seq i_brcs_seq (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_bad_o(cfg_bad_o),
    .async_mode_o(async_mode_o), .busy_o(busy_o), .burst_clk_i(kclk), .ce_n_i(ce_n),
    .latch_n_i(latch_n), .start_addr_i(saddr), .fetch_stall_i(stall),
    .word_addr_o(waddr), .word_valid_o(wvalid), .ready_o(rdy));

  brcs_host_model i_brcs_host_model (.go_i(go), .rise_i(rise), .stall_i(stall_req),
    .addr_i(st_addr), .want_i(want), .done_o(done), .word_addr_i(waddr),
    .word_valid_i(wvalid), .ready_i(rdy), .kclk_o(kclk), .ce_n_o(ce_n),
    .latch_n_o(latch_n), .stall_o(stall), .addr_o(saddr));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  always #12.5 clk_i = ~clk_i;

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // runs stop well before this; a hang counts as a mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // expected word of a burst: wrap in group, xor, or linear
  function automatic logic [20:0] exp_a(input logic [20:0] s, input int i,
                                         input logic [2:0] len, input logic ord);
    logic [20:0] m;
    m = (len == brcs_pkg::LEN_8) ? 21'h000007 : 21'h000003;
    if (len == brcs_pkg::LEN_CONT) return s + 21'(i);
    if (ord) return (s & ~m) | ((s + 21'(i)) & m);
    return s ^ (21'(i) & m);
  endfunction : exp_a

  // write the word, check readback, then run one frame
  task automatic run(input logic [15:0] w, input logic [20:0] a, input int n, input logic s);
    logic bad;
    int xe;
    int ye;
    bad = (w[13:11] < brcs_pkg::XLAT_MIN_CODE) || (w[13:11] > brcs_pkg::XLAT_MAX_CODE)
      || !(w[2:0] inside {brcs_pkg::LEN_4, brcs_pkg::LEN_8, brcs_pkg::LEN_CONT})
      || (w[13:11] == brcs_pkg::XLAT_MIN_CODE && w[9]);
    xe = (int'(w[13:11]) + 2) * (w[10] ? 2 : 1);
    ye = (w[9] ? 2 : 1) * (w[10] ? 2 : 1);
    cfg_wdata_i = w;
    cfg_wr_i = 1'b1;
    @(posedge clk_i);
    #1 cfg_wr_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("readback", 21'(w & brcs_pkg::CFG_MASK), 21'(cfg_rdata_o));
    chk("bad flag", 21'(bad), 21'(cfg_bad_o));
    chk("async", 21'(w[15]), 21'(async_mode_o));
    rise = w[6];
    st_addr = a;
    want = 5'(n);
    stall_req = s;
    go = 1'b1;
    @(posedge done);
    go = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk("busy", 21'h0, 21'(busy_o));
    if (w[15]) chk("words", 21'h0, 21'(i_brcs_host_model.nrec));
    else begin
      chk("first edge", 21'(9 + xe), 21'(i_brcs_host_model.ge[0]));
      chk("ready in latency", 21'h0, 21'(i_brcs_host_model.rdy10));
      if (!s) chk("spacing", 21'((n - 1) * ye),
        21'(i_brcs_host_model.ge[n-1] - i_brcs_host_model.ge[0]));
      if (w[2:0] != brcs_pkg::LEN_CONT) chk("count", 21'(n), 21'(i_brcs_host_model.nrec));
      for (int i = 0; i < n; i++) chk("word", exp_a(a, i, w[2:0], w[7]),
        i_brcs_host_model.got[i]);
    end
  endtask : run

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    cfg_wr_i = 1'b0;
    cfg_wdata_i = 16'h0000;
    go = 1'b0;
    rise = 1'b1;
    stall_req = 1'b0;
    st_addr = 21'h000000;
    want = 5'h00;
    repeat (16) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("reset word", 21'h008000, 21'(cfg_rdata_o));
    chk("reset async", 21'h1, 21'(async_mode_o));
    chk("reset ready", 21'h1, 21'(rdy));
    run(16'hFFFF, 21'h000001, 4, 1'b0);
    run(16'h10C1, 21'h000001, 4, 1'b0);
    run(16'h3202, 21'h000005, 8, 1'b0);
    run(16'h1C47, 21'h000007, 10, 1'b0);
    run(16'h21C2, 21'h000003, 8, 1'b1);
    // same stalls with late ready timing, so the invalid slot shows in that mode too
    run(16'h20C2, 21'h000004, 8, 1'b1);
    run(16'h2E41, 21'h000003, 4, 1'b0);
    run(16'h1003, 21'h000002, 4, 1'b0);
    run(16'h9201, 21'h000000, 4, 1'b0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
